// [design/mwd_map.svh]
// Register offsets, field positions, reset values and timing counts of the watchdog.
`ifndef MWD_MAP_SVH
`define MWD_MAP_SVH

`define MWD_ADDR_W      8
`define MWD_OFF_FREQ    8'h51
`define MWD_OFF_CTRL    8'hd6
`define MWD_OFF_DIS     8'hd7
`define MWD_OFF_IRQ_ST  8'he0
`define MWD_OFF_IRQ_EN  8'he1
`define MWD_OFF_IRQ_CLR 8'he2

`define MWD_CNT_HI      31
`define MWD_CNT_LO      16
`define MWD_TO_HI       15
`define MWD_TO_LO       0
`define MWD_FREQ_HI     6

`define MWD_TO_RST      16'h03e8
`define MWD_CNT_RST     16'h0000
`define MWD_DIS_MAGIC   32'h0d15ab1e
`define MWD_DIS_ENABLE  32'h00000000
`define MWD_CPL_ALL     16'hffff

`define MWD_FREQ_RST    7'h19
`define MWD_FREQ_MIN    7'h05
`define MWD_FREQ_MAX    7'h64

`define MWD_IRQ_W       3
`define MWD_IRQ_EXP     0
`define MWD_IRQ_NACK    1
`define MWD_IRQ_KICK    2

`define MWD_TICK_US     1000
`define MWD_US_NS       1000

`endif

// [design/mwd_pkg.sv]
// Types shared by the watchdog modules.
package mwd_pkg;

    typedef enum logic [1:0] {
        MWD_OFF  = 2'b00,
        MWD_RUN  = 2'b01,
        MWD_FIRE = 2'b11
    } mwd_state_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } mwd_req_s;

endpackage

// [design/mwd_tick.sv]
// Millisecond tick divider driven by the programmed clock frequency in MHz.
`timescale 1ns/1ps
module mwd_tick #(
    parameter int FREQ_W    = 7,
    parameter int US_PER_MS = 1000,
    parameter int MS_W      = $clog2(US_PER_MS + 1)
) (
    input  wire logic              clk_i,      // System clock.
    input  wire logic              rst_i,      // Asynchronous reset, active high.
    input  wire logic              run_i,      // Count while high.
    input  wire logic              restart_i,  // Restart the millisecond phase.
    input  wire logic [FREQ_W-1:0] freq_mhz_i, // Clock frequency in MHz.
    output logic                   tick_o      // One-cycle pulse per millisecond.
);
    logic [FREQ_W-1:0] cyc_reg;
    logic [MS_W-1:0]   us_reg;
    logic              tick_reg;
    logic [FREQ_W-1:0] cyc_last;
    logic              cyc_wrap;
    logic              us_wrap;

    assign cyc_last = freq_mhz_i - {{(FREQ_W-1){1'b0}}, 1'b1};
    assign cyc_wrap = cyc_reg >= cyc_last;
    assign us_wrap  = us_reg == MS_W'(US_PER_MS - 1);
    assign tick_o   = tick_reg;

    // One microsecond is freq_mhz_i clocks; one millisecond is US_PER_MS of those.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_reg <= '0;
            us_reg  <= '0;
        end else if (restart_i) begin
            cyc_reg <= '0;
            us_reg  <= '0;
        end else if (run_i) begin
            cyc_reg <= cyc_wrap ? '0 : cyc_reg + 1'b1;
            if (cyc_wrap) begin
                us_reg <= us_wrap ? '0 : us_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= run_i && !restart_i && cyc_wrap && us_wrap;
        end
    end
endmodule

// [design/mwd_top.sv]
// Millisecond watchdog: register port, countdown, tile reset on expiry and interrupt.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "mwd_map.svh"
module mwd_top
    import mwd_pkg::*;
#(
    parameter int US_PER_MS = `MWD_TICK_US,
    parameter int CNT_W     = 16,
    parameter int FREQ_W    = 7
) (
    input  wire logic        CLK_I,                // System clock, 5 to 100 MHz as set in the frequency register.
    input  wire logic        RST_I,                // Asynchronous reset, active high.
    input  wire logic [7:0]  ADDR_I,               // Register address.
    input  wire logic [31:0] WDATA_I,              // Write data.
    input  wire logic        WR_I,                 // Write strobe.
    input  wire logic        RD_I,                 // Read strobe.
    input  wire logic        ACTIVE_POWER_STATE_I, // High while the device is active_power_state.
    output logic      [31:0] RDATA_O,              // Read data, the cycle after a read.
    output logic             WR_ACK_O,             // Write accepted, the cycle after a write.
    output logic             WR_NACK_O,            // Write refused, the cycle after a write.
    output logic             TILE_RESET_O,         // One-cycle tile reset on expiry.
    output logic             WDOG_ENABLED_O,       // High while the watchdog is enabled.
    output logic             IRQ_O                 // Level interrupt.
);

    mwd_req_s            req;

    // Registers and their next values; the state codes change one bit per step on the usual path.
    mwd_state_e          state_reg;
    mwd_state_e          state_next;
    logic [CNT_W-1:0]    count_reg;
    logic [CNT_W-1:0]    count_next;
    logic [CNT_W-1:0]    timeout_reg;
    logic [CNT_W-1:0]    timeout_next;
    logic [31:0]         disable_reg;
    logic [FREQ_W-1:0]   freq_reg;
    logic [31:0]         rdata_reg;
    logic                ack_reg;
    logic                nack_reg;
    logic                tile_rst_reg;
    logic [`MWD_IRQ_W-1:0] irq_st_reg;
    logic [`MWD_IRQ_W-1:0] irq_en_reg;

    // Register decode.
    wire                 hit_ctrl;
    wire                 hit_dis;
    wire                 hit_freq;
    wire                 hit_irq_st;
    wire                 hit_irq_en;
    wire                 hit_irq_clr;
    wire                 wr_ctrl;
    wire                 wr_dis;
    wire                 wr_freq;
    wire                 wr_irq_en;
    wire                 wr_irq_clr;

    // Write checks and answers.
    wire [CNT_W-1:0]     wr_timeout;
    wire [CNT_W-1:0]     wr_cpl;
    wire                 cpl_ok;
    wire                 kick_ok;
    wire                 kick_bad;
    wire                 dis_magic;
    wire                 dis_zero;
    wire [FREQ_W-1:0]    wr_freq_val;
    wire                 freq_in_range;
    wire                 freq_bad;
    wire                 nack_now;
    wire                 ack_now;
    wire                 wr_nack;

    // Countdown control.
    wire                 enabling;
    wire                 running;
    wire                 tick_run;
    wire                 tick_restart;
    wire                 tick;
    wire                 expire;
    wire                 count_last;
    wire                 count_step;

    // Interrupt and read path.
    wire [`MWD_IRQ_W-1:0] irq_set;
    wire [`MWD_IRQ_W-1:0] irq_clr;
    wire [31:0]          rd_ctrl;
    wire [31:0]          rd_freq;
    wire [31:0]          rd_irq_st;
    wire [31:0]          rd_irq_en;
    wire [31:0]          rd_mux;

    // Bus request bundle.
    assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

    // Address decode.
    assign hit_ctrl    = req.addr == `MWD_OFF_CTRL;
    assign hit_dis     = req.addr == `MWD_OFF_DIS;
    assign hit_freq    = req.addr == `MWD_OFF_FREQ;
    assign hit_irq_st  = req.addr == `MWD_OFF_IRQ_ST;
    assign hit_irq_en  = req.addr == `MWD_OFF_IRQ_EN;
    assign hit_irq_clr = req.addr == `MWD_OFF_IRQ_CLR;

    // Write strobes per register.
    assign wr_ctrl = req.wr && hit_ctrl;
    assign wr_dis  = req.wr && hit_dis;
    assign wr_freq = req.wr && hit_freq;
    assign wr_irq_en  = req.wr && hit_irq_en;
    assign wr_irq_clr = req.wr && hit_irq_clr;

    // Timeout write check: the two halves XORed together must be all ones.
    assign wr_timeout = req.wdata[`MWD_TO_HI:`MWD_TO_LO];
    assign wr_cpl     = req.wdata[`MWD_CNT_HI:`MWD_CNT_LO];
    assign cpl_ok     = (wr_timeout ^ wr_cpl) == `MWD_CPL_ALL;
    assign kick_ok    = wr_ctrl && cpl_ok;
    assign kick_bad   = wr_ctrl && !cpl_ok;

    // Disable register keys.
    assign dis_magic = wr_dis && (req.wdata == `MWD_DIS_MAGIC);
    assign dis_zero  = wr_dis && (req.wdata == `MWD_DIS_ENABLE);

    // Frequency writes outside the valid range are ignored and refused.
    assign wr_freq_val   = req.wdata[`MWD_FREQ_HI:0];
    assign freq_in_range = (req.wdata[31:`MWD_FREQ_HI+1] == '0)
                        && (wr_freq_val >= `MWD_FREQ_MIN)
                        && (wr_freq_val <= `MWD_FREQ_MAX);
    assign freq_bad      = wr_freq && !freq_in_range;

    // A refused write changes nothing but the NACK status bit; every other write, even to a free address, is accepted.
    assign nack_now = kick_bad || freq_bad;
    assign ack_now  = req.wr && !nack_now;
    assign wr_nack  = req.wr && nack_now;

    // Watchdog state.
    // An enable write while already enabled changes nothing.
    assign enabling = (state_reg == MWD_OFF) && dis_zero && !dis_magic;
    assign running  = state_reg == MWD_RUN;

    // The divider only runs when active_power_state, so sleep freezes count and phase.
    // A tick already in flight when sleep begins still takes its millisecond off.
    assign tick_run     = running && ACTIVE_POWER_STATE_I;
    assign tick_restart = kick_ok || enabling || dis_magic;

    // A tick that finds one or zero left ends the last millisecond; a kick or disable then wins.
    assign count_last = count_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
    assign count_step = running && tick;
    assign expire     = count_step && count_last && !dis_magic && !kick_ok;

    // The divider restarts on every kick, enable and disable, so the next millisecond is whole.
    mwd_tick #(
        .FREQ_W    (FREQ_W),
        .US_PER_MS (US_PER_MS)
    ) u_tick (
        .clk_i      (CLK_I),
        .rst_i      (RST_I),
        .run_i      (tick_run),
        .restart_i  (tick_restart),
        .freq_mhz_i (freq_reg),
        .tick_o     (tick)
    );

    // Next state.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            MWD_OFF: begin
                if (enabling) begin
                    state_next = MWD_RUN;
                end
            end
            MWD_RUN: begin
                if (dis_magic) begin
                    state_next = MWD_OFF;
                end else if (expire) begin
                    state_next = MWD_FIRE;
                end
            end
            MWD_FIRE: begin
                if (dis_magic) begin
                    state_next = MWD_OFF;
                end else begin
                    // The firing state lasts one clock; counting then restarts from the timeout.
                    state_next = MWD_RUN;
                end
            end
            default: begin
                state_next = MWD_OFF;
            end
        endcase
    end

    // Programmed timeout is updated only by a well-formed write.
    // A refused write leaves both the timeout and the count untouched.
    assign timeout_next = kick_ok ? wr_timeout : timeout_reg;

    // Next count, highest priority first.
    // A magic write beats everything, so a disable racing an expiry never resets the tile.
    always_comb begin
        count_next = count_reg;
        if (dis_magic) begin
            count_next = `MWD_CNT_RST;
        end else if (enabling) begin
            count_next = timeout_next;
        end else if (state_reg == MWD_OFF) begin
            // While disabled, kicks only store the timeout and ticks do nothing.
            count_next = count_reg;
        end else if (kick_ok) begin
            count_next = wr_timeout;
        end else if (state_reg == MWD_FIRE) begin
            count_next = timeout_reg;
        end else if (expire) begin
            count_next = `MWD_CNT_RST;
        end else if (count_step) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg   <= MWD_OFF;
            count_reg   <= `MWD_CNT_RST;
            timeout_reg <= `MWD_TO_RST;
        end else begin
            state_reg   <= state_next;
            count_reg   <= count_next;
            timeout_reg <= timeout_next;
        end
    end

    // Disable register keeps whatever value was last written.
    // Only zero and the magic value act on the watchdog; other values are just stored.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            disable_reg <= `MWD_DIS_MAGIC;
        end else if (wr_dis) begin
            disable_reg <= req.wdata;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            freq_reg <= `MWD_FREQ_RST;
        end else if (wr_freq && freq_in_range) begin
            // An out-of-range setting leaves the divider on the previous frequency.
            freq_reg <= wr_freq_val;
        end
    end

    // Tile reset pulse is a flop so it cannot glitch.
    // It lasts the single firing cycle, so the tile sees one clean reset request.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tile_rst_reg <= 1'b0;
        end else begin
            tile_rst_reg <= expire;
        end
    end

    // Write answers: every write gets exactly one of them, one cycle after its strobe.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ack_reg  <= 1'b0;
            nack_reg <= 1'b0;
        end else begin
            ack_reg  <= ack_now;
            nack_reg <= wr_nack;
        end
    end

    // Interrupt events; a set in the same cycle as a clear wins.
    assign irq_set[`MWD_IRQ_EXP]  = expire;
    assign irq_set[`MWD_IRQ_NACK] = wr_nack;
    assign irq_set[`MWD_IRQ_KICK] = kick_ok;
    assign irq_clr                = wr_irq_clr ? req.wdata[`MWD_IRQ_W-1:0] : '0;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_st_reg <= '0;
        end else begin
            irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
        end
    end

    // Interrupt enables, laid out like the status bits.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_en_reg <= '0;
        end else if (wr_irq_en) begin
            irq_en_reg <= req.wdata[`MWD_IRQ_W-1:0];
        end
    end

    // Read path: live count above the timeout.
    assign rd_ctrl = {count_reg, timeout_reg};

    // Narrow registers read back zero-extended; free addresses, the clear register among them, read zero.
    assign rd_freq   = {{(32-FREQ_W){1'b0}}, freq_reg};
    assign rd_irq_st = {{(32-`MWD_IRQ_W){1'b0}}, irq_st_reg};
    assign rd_irq_en = {{(32-`MWD_IRQ_W){1'b0}}, irq_en_reg};

    assign rd_mux = hit_ctrl   ? rd_ctrl :
                    hit_dis    ? disable_reg :
                    hit_freq   ? rd_freq :
                    hit_irq_st ? rd_irq_st :
                    hit_irq_en ? rd_irq_en :
                    32'h00000000;

    // Read data stand for one cycle only and are zero otherwise.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_reg <= 32'h00000000;
        end else if (req.rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end

    // Output drive; the firing state still counts as enabled.
    assign RDATA_O        = rdata_reg;
    assign WR_ACK_O       = ack_reg;
    assign WR_NACK_O      = nack_reg;
    assign TILE_RESET_O   = tile_rst_reg;
    assign WDOG_ENABLED_O = state_reg != MWD_OFF;
    assign IRQ_O          = |(irq_st_reg & irq_en_reg);

endmodule

// [bench/mwd_host.sv]
// Register-port master standing in for the processor's configuration channel.
`timescale 1ns/1ps
module mwd_host (
    input  wire logic        clk_i,   // System clock.
    input  wire logic [31:0] rdata_i, // Read data.
    input  wire logic        ack_i,   // Write accepted.
    input  wire logic        nack_i,  // Write refused.
    output logic      [7:0]  addr_o,  // Register address.
    output logic      [31:0] wdata_o, // Write data.
    output logic             wr_o,    // Write strobe.
    output logic             rd_o     // Read strobe.
);
    initial begin
        addr_o  = 8'h00;
        wdata_o = 32'h00000000;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // Returns the answer as {nack, ack}, sampled in the cycle after the strobe.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        #1 r = {nack_i, ack_i};
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        #1 d = rdata_i;
    endtask

    // A kick always carries the timeout with its one's complement above it.
    task automatic kick(input logic [15:0] t, output logic [1:0] r);
        wr(8'hd6, {~t, t}, r);
    endtask
endmodule

// [bench/mwd_top_asserts.sv]
// Concurrent checks on the watchdog ports.
`timescale 1ns/1ps
module mwd_top_asserts (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic [7:0]  ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic        ACTIVE_POWER_STATE_I,
    input wire logic [31:0] RDATA_O,
    input wire logic        WR_ACK_O,
    input wire logic        WR_NACK_O,
    input wire logic        TILE_RESET_O,
    input wire logic        WDOG_ENABLED_O,
    input wire logic        IRQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    wire to_wr  = WR_I && ADDR_I == 8'hd6;
    wire cpl_ok = (WDATA_I[31:16] ^ WDATA_I[15:0]) == 16'hffff;
    wire dis_wr = WR_I && ADDR_I == 8'hd7;
    sequence s_bad_kick; to_wr && !cpl_ok; endsequence
    sequence s_good_kick; to_wr && cpl_ok; endsequence
    a_bad_kick_nack: assert property (s_bad_kick |=> WR_NACK_O && !WR_ACK_O)
        else $error("malformed timeout write not refused");
    a_good_kick_ack: assert property (s_good_kick |=> WR_ACK_O && !WR_NACK_O)
        else $error("valid timeout write not accepted");
    a_write_one_answer: assert property (WR_I |=> $onehot({WR_ACK_O, WR_NACK_O}))
        else $error("write not answered by exactly one of ack and nack");
    a_idle_no_answer: assert property (!WR_I |=> !(WR_ACK_O || WR_NACK_O))
        else $error("ack or nack without a write");
    a_rdata_idle_zero: assert property (!RD_I |=> RDATA_O == 32'h00000000)
        else $error("read data outside the read answer cycle");
    a_zero_enables: assert property (dis_wr && WDATA_I == 32'h00000000 |=> WDOG_ENABLED_O)
        else $error("zero write did not enable the watchdog");
    a_magic_disables: assert property (dis_wr && WDATA_I == 32'h0d15ab1e |=> !WDOG_ENABLED_O)
        else $error("magic write did not disable the watchdog");
    a_magic_no_fire: assert property (dis_wr && WDATA_I == 32'h0d15ab1e |=> !TILE_RESET_O [*4])
        else $error("tile reset after the magic disable write");
    a_tile_one_cycle: assert property (TILE_RESET_O |=> !TILE_RESET_O)
        else $error("tile reset longer than one cycle");
    a_off_no_fire: assert property (!WDOG_ENABLED_O [*2] |=> !TILE_RESET_O)
        else $error("tile reset while disabled");
    a_sleep_no_fire: assert property (!ACTIVE_POWER_STATE_I [*4] |=> !TILE_RESET_O)
        else $error("tile reset while asleep");
endmodule

bind mwd_top mwd_top_asserts u_chk (.CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .ACTIVE_POWER_STATE_I,
    .RDATA_O, .WR_ACK_O, .WR_NACK_O, .TILE_RESET_O, .WDOG_ENABLED_O, .IRQ_O);

// [bench/mwd_top_tb.sv]
// Self-checking testbench of the millisecond watchdog.
`timescale 1ns/1ps
`include "mwd_map.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("Error %s expected %h seen %h", nm, e, g); end end
module mwd_top_tb;
    logic        clk, rst, active, wr, rd, ack, nack, tile_rst, wd_en, irq;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rd_v, rd_w;
    logic [1:0]  resp;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          n_tile = 0;
    int          n;

    mwd_host host (.clk_i(clk), .rdata_i(rdata), .ack_i(ack), .nack_i(nack), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    // Two microseconds per tick at 5 MHz gives one tick every 10 clocks.
    mwd_top #(.US_PER_MS(2)) dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .ACTIVE_POWER_STATE_I(active), .RDATA_O(rdata), .WR_ACK_O(ack), .WR_NACK_O(nack), .TILE_RESET_O(tile_rst),
        .WDOG_ENABLED_O(wd_en), .IRQ_O(irq));

    always @(posedge clk) if (tile_rst === 1'b1) n_tile++;

    task automatic end_of_test();
        $display("Checks made %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        host.rd(`MWD_OFF_CTRL, rd_v);
        `CHK("ctrl reset", 32'h000003e8, rd_v)
        host.rd(`MWD_OFF_DIS, rd_v);
        `CHK("disable reset", `MWD_DIS_MAGIC, rd_v)
        host.rd(8'h40, rd_v);
        `CHK("unmapped read", 32'h00000000, rd_v)
        `CHK("enabled after reset", 1'b0, wd_en)
    endtask

    task automatic t_writes();
        host.wr(`MWD_OFF_CTRL, 32'h00000005, resp);
        `CHK("bad timeout resp", 2'b10, resp)
        host.kick(16'hffff, resp);
        `CHK("max timeout resp", 2'b01, resp)
        host.kick(16'h0003, resp);
        `CHK("good timeout resp", 2'b01, resp)
        host.rd(`MWD_OFF_CTRL, rd_v);
        `CHK("timeout stored", 32'h00000003, rd_v)
        host.wr(`MWD_OFF_FREQ, 32'h00000004, resp);
        `CHK("freq low resp", 2'b10, resp)
        host.wr(`MWD_OFF_FREQ, 32'h00000065, resp);
        `CHK("freq high resp", 2'b10, resp)
        host.wr(`MWD_OFF_FREQ, 32'h00000005, resp);
        `CHK("freq ok resp", 2'b01, resp)
        host.wr(`MWD_OFF_DIS, 32'h12345678, resp);
        `CHK("disable key resp", 2'b01, resp)
        host.rd(`MWD_OFF_DIS, rd_v);
        `CHK("disable key rw", 32'h12345678, rd_v)
        `CHK("nack irq masked", 1'b0, irq)
        host.wr(`MWD_OFF_IRQ_EN, 32'h00000001, resp);
        `CHK("irq enable resp", 2'b01, resp)
        host.rd(`MWD_OFF_IRQ_ST, rd_v);
        `CHK("irq status", 32'h00000006, rd_v)
    endtask

    task automatic t_expire();
        host.wr(`MWD_OFF_DIS, 32'h00000000, resp);
        `CHK("enabled", 1'b1, wd_en)
        host.rd(`MWD_OFF_CTRL, rd_v);
        `CHK("count loaded", 32'h00030003, rd_v)
        n = 0;
        while (tile_rst !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 60) begin
            n_fail++;
            end_of_test();
        end
        `CHK("expiry time", 1'b1, n > 23 && n < 33)
        @(posedge clk);
        #1 `CHK("expiry irq", 1'b1, irq)
        host.wr(`MWD_OFF_IRQ_CLR, 32'h00000001, resp);
        `CHK("irq cleared", 1'b0, irq)
        host.rd(`MWD_OFF_CTRL, rd_v);
        `CHK("count reloaded", 32'h00030003, rd_v)
    endtask

    task automatic t_kick();
        n = n_tile;
        repeat (6) begin
            host.kick(16'h0003, resp);
            repeat (12) @(posedge clk);
        end
        `CHK("kicked no reset", n, n_tile)
    endtask

    task automatic t_sleep();
        @(posedge clk);
        active <= 1'b0;
        host.kick(16'h0003, resp);
        host.rd(`MWD_OFF_CTRL, rd_w);
        n = n_tile;
        repeat (80) @(posedge clk);
        host.rd(`MWD_OFF_CTRL, rd_v);
        `CHK("sleep count", rd_w, rd_v)
        `CHK("sleep no reset", n, n_tile)
        @(posedge clk);
        active <= 1'b1;
    endtask

    task automatic t_disable();
        host.kick(16'h0003, resp);
        repeat (15) @(posedge clk);
        host.wr(`MWD_OFF_DIS, `MWD_DIS_MAGIC, resp);
        `CHK("disabled", 1'b0, wd_en)
        host.rd(`MWD_OFF_CTRL, rd_v);
        `CHK("count cleared", 32'h00000003, rd_v)
        n = n_tile;
        repeat (80) @(posedge clk);
        `CHK("disabled no reset", n, n_tile)
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        rst    = 1'b1;
        active = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_writes();
        t_expire();
        t_kick();
        t_sleep();
        t_disable();
        end_of_test();
    end
endmodule
